// ---- rtl/move_decode.sv ----
// Purpose: decode and execute data-move instruction words
// Assumes: fetch unit presents one word with a valid strobe; memory ports answer same cycle
// Notes:   arithmetic part is outside this block; peripheral register forms are decoded here
// How it works
// - dual move uses lower and upper banks
// - x io wins, y io access dropped
// - shared sources between alu and moves allowed
// - separate direction bits for x and y
// - control move reaches modifiers and controller registers
// - control registers move to memory, registers, immediates
// - stack high read post-decrements pointer
// - stack high write pre-increments pointer
// - status write loads flags from bits 7..0
// - other writes set growth and limit flags
// - immediate short form loads eight bits
// - absolute short takes six-bit address
// - memory control form decoded from upper byte
// - program move between register and p memory
// - high io field maps to top 64
// - low io field maps to next 64
// - x address field is five bits
// - y address field four bits, opposite bank
`timescale 1ns/1ps
`default_nettype none
module move_decode #(
    parameter int WORD_W = 24
) (
    input  wire logic              ref_clk_in,
    input  wire logic              sys_rst_in,
    input  wire logic              instr_valid_in,
    input  wire logic [23:0]       instr_in,
    input  wire logic [191:0]      addr_regs_in,
    input  wire logic [23:0]       src_reg_data_in,
    input  wire logic [23:0]       x_rd_data_in,
    input  wire logic [23:0]       y_rd_data_in,
    input  wire logic [23:0]       p_rd_data_in,
    input  wire logic              growth_in,
    input  wire logic              limit_in,
    output logic                   busy_out,
    output logic                   x_en_out,
    output logic                   x_we_out,
    output logic [23:0]            x_addr_out,
    output logic                   y_en_out,
    output logic                   y_we_out,
    output logic [23:0]            y_addr_out,
    output logic                   p_en_out,
    output logic                   p_we_out,
    output logic [23:0]            p_addr_out,
    output logic [23:0]            wr_data_out,
    output logic [5:0]             src_sel_out,
    output logic [5:0]             dst_sel_out,
    output logic                   dst_we_out,
    output logic [23:0]            dst_data_out,
    output logic [23:0]            stack_pointer_out,
    output logic [7:0]             condition_flags_out
);
    typedef struct packed {
        move_decode_pkg::flow_t      flow;
        move_decode_pkg::move_kind_t kind;
        logic [23:0]                 word;
        logic                        x_en;
        logic                        x_we;
        logic [23:0]                 x_addr;
        logic                        y_en;
        logic                        y_we;
        logic [23:0]                 y_addr;
        logic                        p_en;
        logic                        p_we;
        logic [23:0]                 p_addr;
        logic [23:0]                 wr_data;
        logic [5:0]                  src_sel;
        logic [5:0]                  dst_sel;
        logic                        dst_we;
        logic [23:0]                 dst_data;
        logic [23:0]                 sp;
        logic [7:0]                  flags;
        logic                        pop_pending;
    } state_t;

    state_t st;
    state_t next_st;

    ea_bus_if eax ();
    ea_bus_if eay ();

    ea_calc u_eax (.bus(eax.calculator), .addr_regs_in(addr_regs_in));
    ea_calc u_eay (.bus(eay.calculator), .addr_regs_in(addr_regs_in));

    // instruction fields
    logic        is_dual;
    logic        is_ctrl_mem;
    logic        is_ctrl_reg;
    logic        is_ctrl_imm;
    logic        is_prog;
    logic        x_bank_upper;
    logic [5:0]  ctrl_sel;
    logic [23:0] x_io_addr;
    logic [23:0] y_io_addr;
    logic        x_is_io;
    logic        y_is_io;
    logic        to_reg;
    logic        exec_imm;

    always_comb begin
        is_dual     = instr_in[23];
        is_ctrl_mem = (instr_in[23:16] == move_decode_pkg::OP_CTRL_MEM)
                      && instr_in[7] == 1'b0 && instr_in[5] == 1'b1;
        is_ctrl_reg = (instr_in[23:16] == move_decode_pkg::OP_CTRL_REG)
                      && instr_in[7:6] == 2'b10 && instr_in[5] == 1'b1;
        is_ctrl_imm = (instr_in[23:16] == move_decode_pkg::OP_CTRL_MEM)
                      && instr_in[7:5] == 3'b101;
        is_prog     = (instr_in[23:16] == move_decode_pkg::OP_PROG_MOVE)
                      && instr_in[6] == 1'b0 && instr_in[7] == instr_in[14];
        x_bank_upper = instr_in[10];
        ctrl_sel     = {1'b1, instr_in[4:0]};
        // immediate form has no direction bit: it always writes its register
        to_reg       = instr_in[15] || is_ctrl_imm;
        exec_imm     = st.kind == move_decode_pkg::K_CTRL && st.word[16]
                       && st.word[7:5] == 3'b101;
    end

    // x side: five-bit field, either bank; y side: four bits, other bank
    always_comb begin
        eax.mode_field = {1'b0, instr_in[12:11], instr_in[10:8]};
        eax.upper_bank = x_bank_upper;
        eax.reg_sel    = {1'b0, instr_in[9:8]};
        eax.short_addr = instr_in[13:8];
        eax.use_short  = !is_dual && !instr_in[14];
        eay.mode_field = {2'b00, instr_in[21:20], instr_in[14:13]};
        eay.upper_bank = !x_bank_upper;
        eay.reg_sel    = {1'b0, instr_in[14:13]};
        eay.short_addr = 6'h00;
        eay.use_short  = 1'b0;
    end

    always_comb begin
        x_io_addr = eax.address;
        y_io_addr = eay.address;
        x_is_io   = x_io_addr >= move_decode_pkg::IO_SPACE_LO;
        y_is_io   = y_io_addr >= move_decode_pkg::IO_SPACE_LO;
    end

    always_comb begin
        next_st        = st;
        next_st.dst_we = 1'b0;
        next_st.x_en   = 1'b0;
        next_st.y_en   = 1'b0;
        next_st.p_en   = 1'b0;
        unique case (st.flow)
            move_decode_pkg::F_IDLE: begin
                if (instr_valid_in) begin
                    next_st.word = instr_in;
                    next_st.flow = move_decode_pkg::F_EXEC;
                    next_st.kind = move_decode_pkg::K_NONE;
                    // same source may feed alu and both moves; no blocking here
                    next_st.wr_data = src_reg_data_in;
                    if (is_dual) begin
                        next_st.kind   = move_decode_pkg::K_DUAL;
                        next_st.x_en   = 1'b1;
                        next_st.x_we   = !instr_in[15];
                        next_st.x_addr = x_io_addr;
                        // y io access dropped when both sides hit io
                        next_st.y_en   = !(x_is_io && y_is_io);
                        next_st.y_we   = !instr_in[22];
                        next_st.y_addr = y_io_addr;
                        next_st.src_sel = {2'b00, instr_in[19:18], 2'b00};
                        next_st.dst_sel = {2'b01, instr_in[17:16], 2'b00};
                    end else if (is_ctrl_mem || is_ctrl_imm || is_ctrl_reg) begin
                        next_st.kind    = move_decode_pkg::K_CTRL;
                        next_st.dst_sel = instr_in[15] ? ctrl_sel : instr_in[13:8];
                        next_st.src_sel = instr_in[15] ? instr_in[13:8] : ctrl_sel;
                        if (is_ctrl_imm) begin
                            next_st.dst_sel  = ctrl_sel;
                            next_st.wr_data  = {16'h0000, instr_in[15:8]};
                        end else if (is_ctrl_mem) begin
                            next_st.x_en   = !instr_in[6];
                            next_st.y_en   = instr_in[6];
                            next_st.x_we   = !instr_in[15];
                            next_st.y_we   = !instr_in[15];
                            next_st.x_addr = eax.address;
                            next_st.y_addr = eax.address;
                        end
                    end else if (is_prog) begin
                        next_st.kind   = move_decode_pkg::K_PROG;
                        next_st.p_en   = 1'b1;
                        next_st.p_we   = !instr_in[15];
                        next_st.p_addr = eax.address;
                        next_st.src_sel = instr_in[5:0];
                        next_st.dst_sel = instr_in[5:0];
                    end else if (instr_in[23:17] == move_decode_pkg::OP_PERI_HIGH[7:1]) begin
                        next_st.kind   = move_decode_pkg::K_PERI;
                        next_st.x_en   = !instr_in[6];
                        next_st.y_en   = instr_in[6];
                        next_st.x_we   = !instr_in[15];
                        next_st.y_we   = !instr_in[15];
                        next_st.x_addr = move_decode_pkg::HIGH_IO_BASE | {18'h0, instr_in[5:0]};
                        next_st.y_addr = next_st.x_addr;
                    end else if (instr_in[23:16] == move_decode_pkg::OP_PERI_LOWX) begin
                        next_st.kind   = move_decode_pkg::K_PERI;
                        next_st.x_en   = instr_in[14];
                        next_st.y_en   = !instr_in[14];
                        next_st.x_we   = !instr_in[15];
                        next_st.y_we   = !instr_in[15];
                        next_st.x_addr = move_decode_pkg::LOW_IO_BASE | {18'h0, instr_in[5:0]};
                        next_st.y_addr = next_st.x_addr;
                    end
                    // stack high as destination: bump pointer before the write
                    if (next_st.kind != move_decode_pkg::K_DUAL && next_st.kind != move_decode_pkg::K_NONE
                        && next_st.dst_sel == move_decode_pkg::CR_STACK_HIGH && to_reg) begin
                        next_st.sp = st.sp + 24'h000001;
                    end
                    next_st.pop_pending = next_st.kind != move_decode_pkg::K_NONE
                        && next_st.src_sel == move_decode_pkg::CR_STACK_HIGH && !to_reg;
                end
            end
            move_decode_pkg::F_EXEC: begin
                next_st.flow = move_decode_pkg::F_POST;
                if (st.kind != move_decode_pkg::K_NONE && (st.word[15] || exec_imm)) begin
                    next_st.dst_we = 1'b1;
                    next_st.dst_data = st.p_en ? p_rd_data_in
                                     : st.y_en && !st.x_en ? y_rd_data_in
                                     : st.x_en ? x_rd_data_in : st.wr_data;
                end
            end
            move_decode_pkg::F_POST: begin
                next_st.flow = move_decode_pkg::F_DONE;
                // a pop in the same word wins over the load
                if (st.dst_we && st.dst_sel == move_decode_pkg::CR_STACK_PTR) begin
                    next_st.sp = st.dst_data;
                end
                if (st.pop_pending) begin
                    next_st.sp = st.sp - 24'h000001;
                    next_st.pop_pending = 1'b0;
                end
                if (st.dst_we && st.dst_sel == move_decode_pkg::CR_STATUS) begin
                    next_st.flags = st.dst_data[7:0];
                end else if (st.kind != move_decode_pkg::K_NONE) begin
                    next_st.flags[7] = st.flags[7] | growth_in;
                    next_st.flags[6] = st.flags[6] | limit_in;
                end
            end
            move_decode_pkg::F_DONE: begin
                next_st.flow = move_decode_pkg::F_IDLE;
            end
            default: next_st.flow = move_decode_pkg::F_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            st       <= '0;
            st.flow  <= move_decode_pkg::F_IDLE;
            st.kind  <= move_decode_pkg::K_NONE;
            st.sp    <= move_decode_pkg::STACK_PTR_RST;
            st.flags <= move_decode_pkg::FLAGS_RST;
        end else begin
            st <= next_st;
        end
    end

    // y never reaches io together with x io
    a_io_priority: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        st.kind == move_decode_pkg::K_DUAL && st.x_en && st.x_addr >= move_decode_pkg::IO_SPACE_LO
        && st.y_addr >= move_decode_pkg::IO_SPACE_LO |-> !st.y_en)
        else $error("y io access not discarded");
    a_pop_after: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        st.flow == move_decode_pkg::F_POST && st.pop_pending |=> st.sp == $past(st.sp) - 24'h000001)
        else $error("stack pointer not decremented");
    a_status_load: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        st.flow == move_decode_pkg::F_POST && st.dst_we && st.dst_sel == move_decode_pkg::CR_STATUS
        |=> st.flags == $past(st.dst_data[7:0]))
        else $error("flags not loaded from source");
    a_flow_len: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        st.flow == move_decode_pkg::F_EXEC |=> st.flow == move_decode_pkg::F_POST
        ##1 st.flow == move_decode_pkg::F_DONE)
        else $error("flow sequence broken");
    a_imm_write: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        st.flow == move_decode_pkg::F_EXEC && exec_imm
        |=> st.dst_we && st.dst_data == {16'h0000, $past(st.word[15:8])})
        else $error("immediate not written to control register");
    a_en_pulse: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        st.flow == move_decode_pkg::F_EXEC |=> !st.x_en && !st.y_en && !st.p_en)
        else $error("memory enable held past one cycle");
    a_sp_load: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        st.flow == move_decode_pkg::F_POST && st.dst_we && !st.pop_pending
        && st.dst_sel == move_decode_pkg::CR_STACK_PTR |=> st.sp == $past(st.dst_data))
        else $error("stack pointer not loaded");
    a_bank_split: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        eax.upper_bank != eay.upper_bank)
        else $error("both addresses in one bank");

    assign busy_out            = st.flow != move_decode_pkg::F_IDLE;
    assign x_en_out            = st.x_en;
    assign x_we_out            = st.x_we;
    assign x_addr_out          = st.x_addr;
    assign y_en_out            = st.y_en;
    assign y_we_out            = st.y_we;
    assign y_addr_out          = st.y_addr;
    assign p_en_out            = st.p_en;
    assign p_we_out            = st.p_we;
    assign p_addr_out          = st.p_addr;
    assign wr_data_out         = st.wr_data;
    assign src_sel_out         = st.src_sel;
    assign dst_sel_out         = st.dst_sel;
    assign dst_we_out          = st.dst_we;
    assign dst_data_out        = st.dst_data;
    assign stack_pointer_out   = st.sp;
    assign condition_flags_out = st.flags;
endmodule
`default_nettype wire

// ---- rtl/move_decode_pkg.sv ----
// Purpose: shared constants and types for the data-move instruction decoder
// Assumes: 24-bit instruction words, one word per decode
// Notes:   control register selector codes follow the six-bit field as decoded here
package move_decode_pkg;

    localparam int WORD_W = 24;

    // opcode patterns (upper byte unless noted)
    localparam logic [7:0] OP_CTRL_MEM  = 8'h05; // 0000 0101, bit8 of pattern checked apart
    localparam logic [7:0] OP_CTRL_REG  = 8'h04;
    localparam logic [7:0] OP_PROG_MOVE = 8'h07;
    localparam logic [7:0] OP_PERI_HIGH = 8'h08; // 0000 100s, low bit masked
    localparam logic [7:0] OP_PERI_LOWX = 8'h07;

    // io short address bases
    localparam logic [23:0] HIGH_IO_BASE = 24'hFFFFC0;
    localparam logic [23:0] LOW_IO_BASE  = 24'hFFFF80;
    localparam logic [23:0] IO_SPACE_LO  = 24'hFFFF80;

    // control register selector codes (six-bit field)
    localparam logic [5:0] CR_MOD0       = 6'h20; // 10_0xxx: modifier registers 0..7
    localparam logic [5:0] CR_VECTOR     = 6'h30;
    localparam logic [5:0] CR_STATUS     = 6'h39;
    localparam logic [5:0] CR_MODE       = 6'h3A;
    localparam logic [5:0] CR_STACK_PTR  = 6'h3B;
    localparam logic [5:0] CR_STACK_LOW  = 6'h3D;
    localparam logic [5:0] CR_STACK_HIGH = 6'h3C;
    localparam logic [5:0] CR_LOOP_ADDR  = 6'h3E;
    localparam logic [5:0] CR_LOOP_CNT   = 6'h3F;

    // reset values
    localparam logic [23:0] STACK_PTR_RST = 24'h000000;
    localparam logic [7:0]  FLAGS_RST     = 8'h00;

    typedef enum logic [4:0] {
        K_NONE  = 5'b00001,
        K_DUAL  = 5'b00010,
        K_CTRL  = 5'b00100,
        K_PROG  = 5'b01000,
        K_PERI  = 5'b10000
    } move_kind_t;

    typedef enum logic [3:0] {
        F_IDLE = 4'b0001,
        F_EXEC = 4'b0010,
        F_POST = 4'b0100,
        F_DONE = 4'b1000
    } flow_t;

endpackage

// ---- rtl/ea_bus_if.sv ----
// Purpose: carries one decoded effective-address request between decoder modules
// Assumes: single clock, same domain on both sides
// Notes:   consumer is the address calculator
`timescale 1ns/1ps
`default_nettype none
interface ea_bus_if;
    logic [5:0] mode_field;
    logic       upper_bank;
    logic [2:0] reg_sel;
    logic [5:0] short_addr;
    logic       use_short;
    logic [23:0] address;

    modport requester (output mode_field, output upper_bank, output reg_sel,
                       output short_addr, output use_short, input address);
    modport calculator (input mode_field, input upper_bank, input reg_sel,
                        input short_addr, input use_short, output address);
endinterface
`default_nettype wire

// ---- rtl/ea_calc.sv ----
// Purpose: forms an effective address from a mode field or a short address
// Assumes: address register values arrive from the address unit
// Notes:   register-indirect and short absolute forms are resolved; update of pointers is outside
`timescale 1ns/1ps
`default_nettype none
module ea_calc (
    ea_bus_if.calculator  bus,
    input  wire logic [191:0] addr_regs_in
);
    logic [2:0]  idx;
    logic [23:0] base;

    always_comb begin
        idx  = bus.reg_sel;
        base = addr_regs_in[{bus.upper_bank, idx[1:0]} * 24 +: 24];
        if (!bus.upper_bank && bus.mode_field[2]) begin
            base = addr_regs_in[idx * 24 +: 24];
        end
        // short form bypasses the registers entirely
        if (bus.use_short) begin
            bus.address = {18'h0, bus.short_addr};
        end else begin
            bus.address = base;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/mem_side_model.sv ----
// Purpose: far-side memory model for the move decoder (x, y and p buses)
// Assumes: a read answers in the same cycle as its enable
// Notes:   a released bus shows a pattern that flips every cycle, never stale data
`timescale 1ns/1ps
`default_nettype none
module mem_side_model (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        x_en_in,
    input  wire logic [23:0] x_addr_in,
    input  wire logic        y_en_in,
    input  wire logic [23:0] y_addr_in,
    input  wire logic        p_en_in,
    input  wire logic [23:0] p_addr_in,
    output logic      [23:0] x_rd_out,
    output logic      [23:0] y_rd_out,
    output logic      [23:0] p_rd_out
);
    localparam logic [23:0] PAT = 24'h5A5A5A;
    logic [23:0] junk;
    // toggling idle value, so a late sample by the decoder cannot pass by luck
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            junk <= 24'h0F0F0F;
        end else begin
            junk <= ~junk;
        end
    end
    assign x_rd_out = x_en_in ? (x_addr_in ^ PAT) : junk;
    assign y_rd_out = y_en_in ? (y_addr_in ^ PAT) : ~junk;
    assign p_rd_out = p_en_in ? (p_addr_in ^ PAT) : junk;
endmodule
`default_nettype wire

// ---- testbench/data_move_instruction_decode_test.sv ----
// Purpose: self-checking bench for the data-move decoder
// Assumes: one word in flight; outputs sampled 1 ns after each rising edge
// Notes:   a peripheral move drives only its io access, on the space its own bit picks
`timescale 1ns/1ps
`default_nettype none
module data_move_instruction_decode_test;
    typedef struct packed {
        logic [23:0] w;
        logic [8:0]  f;   // io xe ye pe wck wdc xw yw pw
        logic [23:0] xa;
        logic [23:0] ya;
        logic [23:0] pa;
    } row_t;
    localparam logic [23:0] SRC = 24'h3C3C3C;
    logic         ref_clk_in, sys_rst_in, valid, gr, lim;
    logic         busy, xe, xw, ye, yw, pe, pw, dwe;
    logic         cx, cy, cp, cxw, cyw, cpw, cdw;
    logic [23:0]  instr, xrd, yrd, prd, xa, ya, pa, wd, dd, sp;
    logic [23:0]  cxa, cya, cpa, cwd, cdd;
    logic [191:0] regs;
    logic [5:0]   ss, ds;
    logic [5:0]   codes [16];
    logic [7:0]   fl;
    integer       bad_count, cmp_count, npulse, k;
    row_t         rows [9];

    move_decode move_decode_inst (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .instr_valid_in(valid), .instr_in(instr), .addr_regs_in(regs), .src_reg_data_in(SRC),
        .x_rd_data_in(xrd), .y_rd_data_in(yrd), .p_rd_data_in(prd), .growth_in(gr),
        .limit_in(lim), .busy_out(busy), .x_en_out(xe), .x_we_out(xw), .x_addr_out(xa),
        .y_en_out(ye), .y_we_out(yw), .y_addr_out(ya), .p_en_out(pe), .p_we_out(pw),
        .p_addr_out(pa), .wr_data_out(wd), .src_sel_out(ss), .dst_sel_out(ds),
        .dst_we_out(dwe), .dst_data_out(dd), .stack_pointer_out(sp), .condition_flags_out(fl));
    mem_side_model mem_side_model_inst (.clk_in(ref_clk_in), .rst_in(sys_rst_in),
        .x_en_in(xe), .x_addr_in(xa), .y_en_in(ye), .y_addr_in(ya), .p_en_in(pe),
        .p_addr_in(pa), .x_rd_out(xrd), .y_rd_out(yrd), .p_rd_out(prd));

    initial begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end

    function automatic logic [191:0] regset(input logic [23:0] base);
        logic [191:0] r;
        for (int n = 0; n < 8; n++) r[n*24 +: 24] = base | 24'(n);
        return r;
    endfunction

    function automatic logic [23:0] imm(input logic [7:0] v, input logic [5:0] code);
        return {8'h05, v, 2'b10, code};
    endfunction

    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // issue one word, then watch five cycles and keep the first enable pulse
    task automatic run(input logic [23:0] w);
        integer i;
        i = 0;
        while (busy !== 1'b0 && i < 10) begin
            @(posedge ref_clk_in);
            #1;
            i++;
        end
        if (i == 10) begin
            bad_count++;
            report_and_stop;
        end
        valid = 1'b1;
        instr = w;
        @(posedge ref_clk_in);
        #1;
        valid = 1'b0;
        npulse = 0;
        cdw = 1'b0;
        {cx, cy, cp} = 3'b000;
        for (i = 0; i < 5; i++) begin
            if ((xe | ye | pe) === 1'b1) begin
                npulse++;
                if (npulse == 1) begin
                    {cx, cy, cp, cxw, cyw, cpw} = {xe, ye, pe, xw, yw, pw};
                    {cxa, cya, cpa, cwd} = {xa, ya, pa, wd};
                end
            end
            if (dwe === 1'b1) begin
                cdw = 1'b1;
                cdd = dd;
            end
            @(posedge ref_clk_in);
            #1;
        end
    endtask

    initial begin
        bad_count = 0;
        cmp_count = 0;
        {valid, gr, lim, sys_rst_in} = 4'b0001;
        instr = 24'h000000;
        regs = regset(24'h0A0000);
        // every program word keeps the alu part empty and the two destinations apart
        rows[0] = '{24'hF0D900, 9'b011010000, 24'h0A0001, 24'h0A0006, 24'h0};
        rows[1] = '{24'hB03D00, 9'b011010110, 24'h0A0005, 24'h0A0001, 24'h0};
        rows[2] = '{24'hF01B00, 9'b011010100, 24'h0A0003, 24'h0A0004, 24'h0};
        rows[3] = '{24'hB0FF00, 9'b011010010, 24'h0A0007, 24'h0A0003, 24'h0};
        rows[4] = '{24'h05AA3A, 9'b010010000, 24'h00002A, 24'h0, 24'h0};
        rows[5] = '{24'h052A7A, 9'b001010010, 24'h0, 24'h00002A, 24'h0};
        rows[6] = '{24'h071504, 9'b000111001, 24'h0, 24'h0, 24'h000015};
        rows[7] = '{24'h07E04A, 9'b010000000, 24'hFFFF8A, 24'h0, 24'h0};
        rows[8] = '{24'hF0D900, 9'b110010000, 24'hFFFF81, 24'h0, 24'h0};
        for (k = 0; k < 8; k++) codes[k] = move_decode_pkg::CR_MOD0 | 6'(k);
        codes[8] = move_decode_pkg::CR_VECTOR;
        codes[9] = move_decode_pkg::CR_STATUS;
        codes[10] = move_decode_pkg::CR_MODE;
        codes[11] = move_decode_pkg::CR_STACK_HIGH;
        codes[12] = move_decode_pkg::CR_STACK_LOW;
        codes[13] = move_decode_pkg::CR_LOOP_ADDR;
        codes[14] = move_decode_pkg::CR_LOOP_CNT;
        codes[15] = move_decode_pkg::CR_STACK_PTR;
        repeat (8) @(posedge ref_clk_in);
        #1;
        chk("busy_in_reset", 24'(busy), 24'h0);
        sys_rst_in = 1'b0;
        @(posedge ref_clk_in);
        #1;
        chk("sp_after_reset", sp, move_decode_pkg::STACK_PTR_RST);
        chk("flags_after_reset", 24'(fl), 24'(move_decode_pkg::FLAGS_RST));
        for (k = 0; k < 9; k++) begin
            regs = regset(rows[k].f[8] ? 24'hFFFF80 : 24'h0A0000);
            run(rows[k].w);
            chk("x_en", 24'(cx), 24'(rows[k].f[7]));
            chk("y_en", 24'(cy), 24'(rows[k].f[6]));
            chk("p_en", 24'(cp), 24'(rows[k].f[5]));
            chk("pulses", 24'(npulse), 24'h1);
            if (rows[k].f[7]) chk("x_addr", cxa, rows[k].xa);
            if (rows[k].f[6]) chk("y_addr", cya, rows[k].ya);
            if (rows[k].f[5]) chk("p_addr", cpa, rows[k].pa);
            if (rows[k].f[4] && cx) chk("x_we", 24'(cxw), 24'(rows[k].f[2]));
            if (rows[k].f[4] && cy) chk("y_we", 24'(cyw), 24'(rows[k].f[1]));
            if (rows[k].f[4] && cp) chk("p_we", 24'(cpw), 24'(rows[k].f[0]));
            if (rows[k].f[3]) chk("wr_data", cwd, SRC);
        end
        regs = regset(24'h0A0000);
        for (k = 0; k < 16; k++) begin
            run(imm(8'h00, codes[k]));
            chk("dst_sel", 24'(ds), 24'(codes[k]));
        end
        run(imm(8'h10, move_decode_pkg::CR_STACK_PTR));
        chk("sp_load", sp, 24'h000010);
        run(imm(8'h00, move_decode_pkg::CR_STACK_HIGH));
        chk("sp_push", sp, 24'h000011);
        run(imm(8'h00, move_decode_pkg::CR_STACK_HIGH));
        chk("sp_push2", sp, 24'h000012);
        run({8'h04, 2'b01, 6'h04, 2'b10, move_decode_pkg::CR_STACK_HIGH});
        chk("sp_pop", sp, 24'h000011);
        // growth and limit raised on purpose: a status write must ignore them
        {gr, lim} = 2'b11;
        run(imm(8'hA5, move_decode_pkg::CR_STATUS));
        chk("flags_load", 24'(fl), 24'h0000A5);
        {gr, lim} = 2'b00;
        run(imm(8'h00, move_decode_pkg::CR_STATUS));
        chk("flags_clear", 24'(fl), 24'h000000);
        gr = 1'b1;
        run(imm(8'h00, move_decode_pkg::CR_MODE));
        chk("flags_growth", 24'(fl), 24'h000080);
        {gr, lim} = 2'b01;
        run(imm(8'h00, move_decode_pkg::CR_MODE));
        chk("flags_limit", 24'(fl), 24'h0000C0);
        lim = 1'b0;
        run(24'h079504);
        chk("p_read_we", 24'(cdw), 24'h1);
        chk("p_read_data", cdd, 24'h000015 ^ 24'h5A5A5A);
        run(24'h09E085);
        chk("io_high", cxa, 24'hFFFFC5);
        chk("io_high_side", 24'({cx, cy}), 24'h2);
        run(24'h09E0C5);
        chk("io_high_y", cya, 24'hFFFFC5);
        chk("io_high_y_side", 24'({cx, cy}), 24'h1);
        report_and_stop;
    end
endmodule
`default_nettype wire
